//--- core/aad_pkg.sv
// shared constants and carrier types for the adapter address decode block
// assumes a single 200 MHz system clock and host pins that arrive unsynchronised
package aad_pkg;

   // host address line positions
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned A_BYTE      = 0;
   localparam int unsigned A_LVL_LO    = 0;
   localparam int unsigned A_LVL_HI    = 2;
   localparam int unsigned A_ZERO3     = 3;
   localparam int unsigned A_SPLIT4    = 4;
   localparam int unsigned A_ONE5      = 5;
   localparam int unsigned A_ONE6      = 6;
   localparam int unsigned A_ONE7      = 7;
   localparam int unsigned A_ZERO8     = 8;
   localparam int unsigned A_ONE9      = 9;
   localparam int unsigned A_NUM_LO    = 10;
   localparam int unsigned A_NUM_HI    = 11;
   localparam int unsigned A_WORD_LO   = 12;
   localparam int unsigned A_WORD_HI   = 14;
   localparam int unsigned A_BANK      = 15;

   // value of A4 that splits adapter window from shared interrupt address
   localparam logic        A4_ADAPTER  = 1'h0;
   localparam logic        A4_SHARED   = 1'h1;
   // adapter number field of the shared interrupt address (02Fx)
   localparam logic [1:0]  SHARED_NUM  = 2'h0;

   // legal interrupt levels
   localparam logic [2:0]  LEVEL_MIN   = 3'h3;
   localparam logic [2:0]  LEVEL_MAX   = 3'h7;

   // depth of the pin synchroniser
   localparam int unsigned SYNC_STAGES = 3;

   // raw host pins, all asynchronous to sys_clk_i
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              aen;
      logic              ior_n;
      logic              iow_n;
      logic              reset_drv;
      logic              adapter_number_switch_1;
      logic              adapter_number_switch_0;
      logic [2:0]        irq_level;
   } aad_host_s;

   localparam int unsigned HOST_W = $bits(aad_host_s);

   // idle pin image used while the synchroniser is in reset
   localparam aad_host_s HOST_RST = '{
      addr:                    16'h0000,
      aen:                     1'h1,
      ior_n:                   1'h1,
      iow_n:                   1'h1,
      reset_drv:               1'h1,
      adapter_number_switch_1: 1'h0,
      adapter_number_switch_0: 1'h0,
      irq_level:               3'h3
   };

   // decoded and buffered control outputs
   typedef struct packed {
      logic       pre_select;
      logic       card_select;
      logic       irq_rearm;
      logic       buffered_reset_n;
      logic [2:0] word_select;
      logic       word_bank;
      logic       byte_select;
      logic       buffered_io_read_n;
      logic       buffered_io_write_n;
      logic       transfer_is_read;
      logic       transfer_is_write;
      logic       strobe_read_en;
      logic       strobe_write_en;
   } aad_ctrl_s;

   // output image after reset: host reset seen, everything else idle
   localparam aad_ctrl_s CTRL_RST = '{
      pre_select:          1'h0,
      card_select:         1'h0,
      irq_rearm:           1'h1,
      buffered_reset_n:    1'h0,
      word_select:         3'h0,
      word_bank:           1'h0,
      byte_select:         1'h0,
      buffered_io_read_n:  1'h1,
      buffered_io_write_n: 1'h1,
      transfer_is_read:    1'h0,
      transfer_is_write:   1'h1,
      strobe_read_en:      1'h0,
      strobe_write_en:     1'h0
   };

endpackage

//--- core/aad_pin_sync.sv
// three stage pin synchroniser with a two stage agreement filter
// assumes inputs are asynchronous levels; bits are filtered independently
`timescale 1ns/1ps
module aad_pin_sync #(
   parameter int unsigned       W       = 1,
   parameter logic [W-1:0]      RST_VAL = '0
) (
   // clock and reset
   input  wire logic            sys_clk_i,
   input  wire logic            resetn_i,
   // raw pins and filtered result
   input  wire logic [W-1:0]    pin_i,
   output logic      [W-1:0]    pin_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] stage2_r;
   logic [W-1:0] stage3_r;
   logic [W-1:0] out_r;
   logic [W-1:0] agree;

   // a bit moves only once the second and third stage agree
   assign agree = ~(stage2_r ^ stage3_r);

   // meta_r feeds stage2_r only, never any logic
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         meta_r   <= RST_VAL;
         stage2_r <= RST_VAL;
         stage3_r <= RST_VAL;
         out_r    <= RST_VAL;
      end
      else
      begin
         meta_r   <= pin_i;
         stage2_r <= meta_r;
         stage3_r <= stage2_r;
         out_r    <= (agree & stage3_r) | (~agree & out_r);
      end
   end

   assign pin_o = out_r;

endmodule // aad_pin_sync

//--- core/aad_decode.sv
// address decode front end of the host I/O channel adapter
// assumes host pins arrive asynchronously and are held over the whole cycle
// pins reach the outputs five system clocks after they settle
`timescale 1ns/1ps
module aad_decode (
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  resetn_i,
   // host channel pins and switches
   input  wire aad_pkg::aad_host_s    host_i,
   // decoded controls toward the strobe logic
   output aad_pkg::aad_ctrl_s         ctrl_o
);

   // synchronised host view
   aad_pkg::aad_host_s host_q;
   logic [aad_pkg::HOST_W-1:0] host_raw;
   logic [aad_pkg::HOST_W-1:0] host_flt;

   // output register and its next value
   aad_pkg::aad_ctrl_s ctrl_r;
   aad_pkg::aad_ctrl_s ctrl_nxt;

   // flatten the pin image for the width-generic filter
   assign host_raw = host_i;

   // pins cross into the system clock; the cycle is slow, so latency is free
   aad_pin_sync #(
      .W       (aad_pkg::HOST_W),
      .RST_VAL (aad_pkg::HOST_RST)
   ) aad_pin_sync_i (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .pin_i     (host_raw),
      .pin_o     (host_flt)
   );

   // back to named fields once filtered
   assign host_q = aad_pkg::aad_host_s'(host_flt);

   // named address fields, one wire per decoded line
   logic [aad_pkg::ADDR_W-1:0] addr;
   logic                       a0;
   logic                       a3;
   logic                       a4;
   logic                       a5;
   logic                       a6;
   logic                       a7;
   logic                       a8;
   logic                       a9;

   // fields wider than one line, and the one-line bank bit
   logic [1:0]                 num_field;
   logic [2:0]                 low_digit;
   logic [2:0]                 word_field;
   logic                       bank_bit;

   // filtered address, A15 down to A0
   assign addr       = host_q.addr;

   // lines shared by the adapter window and the shared interrupt address
   assign a3         = addr[aad_pkg::A_ZERO3];
   assign a5         = addr[aad_pkg::A_ONE5];
   assign a6         = addr[aad_pkg::A_ONE6];
   assign a7         = addr[aad_pkg::A_ONE7];
   assign a8         = addr[aad_pkg::A_ZERO8];
   assign a9         = addr[aad_pkg::A_ONE9];

   // lines that tell the adapter copies and the shared address apart
   assign a4         = addr[aad_pkg::A_SPLIT4];
   assign num_field  = addr[aad_pkg::A_NUM_HI:aad_pkg::A_NUM_LO];
   assign low_digit  = addr[aad_pkg::A_LVL_HI:aad_pkg::A_LVL_LO];

   // lines that only pass through toward the strobe logic
   assign a0         = addr[aad_pkg::A_BYTE];
   assign word_field = addr[aad_pkg::A_WORD_HI:aad_pkg::A_WORD_LO];
   assign bank_bit   = addr[aad_pkg::A_BANK];

   // switches and interrupt level
   logic [1:0] adapter_number;
   logic [2:0] irq_level;
   logic       level_low_ok;
   logic       level_high_ok;
   logic       level_legal;

   // command terms, active high inside the block
   logic       host_dma;
   logic       io_read;
   logic       io_write;
   logic       io_cmd;
   logic       host_reset;

   // switches are static, but still pass the filter with the other pins
   assign adapter_number = {host_q.adapter_number_switch_1,
                            host_q.adapter_number_switch_0};
   assign irq_level      = host_q.irq_level;

   // levels 0 to 2 are not wired to the shared line, so never match
   assign level_low_ok  = (irq_level >= aad_pkg::LEVEL_MIN);
   assign level_high_ok = (irq_level <= aad_pkg::LEVEL_MAX);
   assign level_legal   = level_low_ok & level_high_ok;

   // dma owns the channel while address enable is high
   assign host_dma = host_q.aen;

   // channel commands are active low; decode works on active high copies
   assign io_read    = ~host_q.ior_n;
   assign io_write   = ~host_q.iow_n;
   assign io_cmd     = io_read | io_write;
   assign host_reset = host_q.reset_drv;

   // preselect: bits shared by adapter window and shared interrupt
   logic common_ones;
   logic common_zeros;
   logic common_bits;
   logic pre_select;

   // lines that must read one, and lines that must read zero
   assign common_ones  = a9 & a7 & a6 & a5;
   assign common_zeros = ~a8 & ~a3;
   assign common_bits  = common_ones & common_zeros;
   assign pre_select   = common_bits & ~host_dma;

   // card select: adapter window 2E2..2E3 for this adapter number
   logic number_match;
   logic window_hit;
   logic card_select;

   // A2 and A1 are left undecoded, so the window aliases within its block
   assign number_match = (num_field == adapter_number);
   assign window_hit   = (a4 == aad_pkg::A4_ADAPTER);
   // the A4 split keeps shared interrupt accesses out of card select
   assign card_select  = pre_select & window_hit & number_match;

   // shared interrupt re-arm at 02Fx, x = configured level
   logic shared_split;
   logic shared_number;
   logic shared_hit;
   logic level_match;
   logic rearm_addr;

   // the shared address sits at adapter number zero with A4 set
   assign shared_split  = (a4 == aad_pkg::A4_SHARED);
   assign shared_number = (num_field == aad_pkg::SHARED_NUM);
   assign shared_hit    = shared_split & shared_number;
   // an unwired level voids the match whatever the low digit says
   assign level_match   = (low_digit == irq_level) & level_legal;
   // qualified by a command so a passing address alone does not re-arm
   assign rearm_addr    = pre_select & shared_hit & level_match & io_cmd;

   // buffered reset and re-arm at power-on
   logic buffered_reset_n;
   logic power_on_rearm;
   logic irq_rearm;

   // host reset is active high; the control logic wants it active low
   assign buffered_reset_n = ~host_reset;
   // re-arm stands for as long as the reset driver does, not one pulse
   assign power_on_rearm   = ~buffered_reset_n;
   assign irq_rearm        = rearm_addr | power_on_rearm;

   // buffered address, byte and command lines
   logic [2:0] word_select;
   logic       word_bank;
   logic       byte_select;
   logic       buffered_io_read_n;
   logic       buffered_io_write_n;

   // plain copies; gating is left to the strobe decode downstream
   assign word_select         = word_field;
   assign word_bank           = bank_bit;
   assign byte_select         = a0;
   assign buffered_io_read_n  = host_q.ior_n;
   assign buffered_io_write_n = host_q.iow_n;

   // transfer direction on the wide data bus
   logic transfer_is_read;
   logic transfer_is_write;

   // idle counts as write so the wide bus is never turned toward the host
   assign transfer_is_read  = io_read;
   assign transfer_is_write = ~transfer_is_read;

   // strobe enables for the control decode, gated by card select
   logic strobe_read_en;
   logic strobe_write_en;

   // both stay low while another card or the shared address is addressed
   assign strobe_read_en  = card_select & io_read;
   assign strobe_write_en = card_select & io_write;

   // next output image; purely combinational on a held cycle
   always_comb
   begin
      ctrl_nxt                     = aad_pkg::CTRL_RST;
      ctrl_nxt.pre_select          = pre_select;
      ctrl_nxt.card_select         = card_select;
      ctrl_nxt.irq_rearm           = irq_rearm;
      ctrl_nxt.buffered_reset_n    = buffered_reset_n;
      ctrl_nxt.word_select         = word_select;
      ctrl_nxt.word_bank           = word_bank;
      ctrl_nxt.byte_select         = byte_select;
      ctrl_nxt.buffered_io_read_n  = buffered_io_read_n;
      ctrl_nxt.buffered_io_write_n = buffered_io_write_n;
      ctrl_nxt.transfer_is_read    = transfer_is_read;
      ctrl_nxt.transfer_is_write   = transfer_is_write;
      ctrl_nxt.strobe_read_en      = strobe_read_en;
      ctrl_nxt.strobe_write_en     = strobe_write_en;
   end

   // registered outputs, so downstream never sees decode glitches;
   // a stable cycle still relies on the host holding its pins
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         ctrl_r <= aad_pkg::CTRL_RST;
      else
         ctrl_r <= ctrl_nxt;
   end

   assign ctrl_o = ctrl_r;

endmodule // aad_decode

//--- tb/aad_decode_chk.sv
// port assertions for the adapter address decode block
// assumes host pins are judged only after seven quiet clocks
`timescale 1ns/1ps
module aad_decode_chk (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   // watched ports
   input  wire aad_pkg::aad_host_s host_i,
   input  wire aad_pkg::aad_ctrl_s ctrl_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   // expected decode from the pins, kept apart from any sampling
   wire logic [15:0] a_w    = host_i.addr;
   wire logic        pre_w  = !host_i.aen && (a_w[9:5] == 5'h17) && !a_w[3];
   wire logic        card_w = pre_w && !a_w[4] && (a_w[11:10] ==
                              {host_i.adapter_number_switch_1, host_i.adapter_number_switch_0});
   wire logic        hit_w  = pre_w && a_w[4] && (a_w[11:10] == 2'h0) &&
                              (a_w[2:0] == host_i.irq_level) && (host_i.irq_level >= 3'h3) &&
                              !(host_i.ior_n && host_i.iow_n);

   // pins quiet long enough to clear the five stage pipe, with two cycles of margin
   sequence s_settled;
      (resetn_i && $stable(host_i)) [*7];
   endsequence
   sequence s_dma_owned;
      s_settled ##0 host_i.aen;
   endsequence

   a_aen_blocks: assert property (s_dma_owned |-> !ctrl_o.pre_select && !ctrl_o.card_select
      && !ctrl_o.strobe_read_en && !ctrl_o.strobe_write_en) else $error("decode seen under dma");
   a_pre_select_decode: assert property (s_settled |-> ctrl_o.pre_select == pre_w)
      else $error("preselect wrong");
   a_card_decode: assert property (s_settled |-> ctrl_o.card_select == card_w)
      else $error("card select wrong");
   a_strobe_gate: assert property (s_settled |-> ctrl_o.strobe_read_en == (card_w &&
      !host_i.ior_n) && ctrl_o.strobe_write_en == (card_w && !host_i.iow_n))
      else $error("strobe enable not gated by card select");
   a_rearm_addr: assert property (s_settled ##0 !host_i.reset_drv |->
      ctrl_o.irq_rearm == hit_w) else $error("rearm address decode wrong");
   a_rearm_reset: assert property (s_settled ##0 host_i.reset_drv |-> ctrl_o.irq_rearm)
      else $error("no rearm during host reset");
   a_reset_inverse: assert property (s_settled |->
      ctrl_o.buffered_reset_n == !host_i.reset_drv) else $error("buffered reset wrong");
   a_word_pass: assert property (s_settled |-> {ctrl_o.word_bank, ctrl_o.word_select,
      ctrl_o.byte_select} == {a_w[15:12], a_w[0]}) else $error("word or byte select wrong");
   a_cmd_copy: assert property (s_settled |-> ctrl_o.buffered_io_read_n == host_i.ior_n &&
      ctrl_o.buffered_io_write_n == host_i.iow_n) else $error("buffered command wrong");
   a_dir_flags: assert property (s_settled |-> ctrl_o.transfer_is_read == !host_i.ior_n &&
      ctrl_o.transfer_is_write == host_i.ior_n) else $error("direction flags wrong");
   a_out_steady: assert property ((resetn_i && $stable(host_i)) [*8] |-> $stable(ctrl_o))
      else $error("output moved under held pins");
endmodule // aad_decode_chk

//--- tb/aad_host_model.sv
// host processor and dma controller model driving the channel pins
// assumes tasks are called from the bench; pins change at falling edges
`timescale 1ns/1ps
module aad_host_model (
   // clock
   input  wire logic          sys_clk_i,
   // host pins toward the adapter
   output aad_pkg::aad_host_s host_o
);
   // power-up: reset driver high, dma owns the bus, commands idle
   initial
   begin
      host_o = aad_pkg::HOST_RST;
   end

   // one i/o cycle; released address lines never keep their last value
   task automatic drive(input logic [15:0] addr, input logic aen, input logic ior_n,
                        input logic iow_n);
      @(negedge sys_clk_i);
      host_o.addr = ~host_o.addr;
      host_o.ior_n = 1'h1;
      host_o.iow_n = 1'h1;
      @(negedge sys_clk_i);
      host_o.addr = addr;
      host_o.aen = aen;
      host_o.ior_n = ior_n;
      host_o.iow_n = iow_n; // held until the next cycle
   endtask

   // reset driver, adapter number switches and interrupt level
   task automatic set_cfg(input logic drv, input logic [1:0] num, input logic [2:0] lvl);
      @(negedge sys_clk_i);
      host_o.reset_drv = drv;
      host_o.adapter_number_switch_1 = num[1];
      host_o.adapter_number_switch_0 = num[0];
      host_o.irq_level = lvl;
   endtask
endmodule // aad_host_model

//--- tb/aad_decode_bench.sv
// self-checking bench for the adapter address decode block
// assumes the host model holds each cycle until the bench has judged it
`timescale 1ns/1ps
module aad_decode_bench;
   localparam int      LIMIT = 5000;
   logic               sys_clk_i;
   logic               resetn_i;
   aad_pkg::aad_host_s host_w;
   aad_pkg::aad_ctrl_s ctrl_w;
   int                 miscompares;
   int                 n_checks;
   int                 cyc_cnt;

   aad_host_model aad_host_model_i (.sys_clk_i(sys_clk_i), .host_o(host_w));
   aad_decode aad_decode_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_i(host_w),
                            .ctrl_o(ctrl_w));

   always #2.5 sys_clk_i = ~sys_clk_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // reference outputs worked out from the pins
   function automatic aad_pkg::aad_ctrl_s ref_ctrl(input aad_pkg::aad_host_s h);
      aad_pkg::aad_ctrl_s r;
      logic [15:0]        a;
      a = h.addr;
      r.pre_select = !h.aen && (a[9:5] == 5'h17) && !a[3];
      r.card_select = r.pre_select && !a[4] &&
                      (a[11:10] == {h.adapter_number_switch_1, h.adapter_number_switch_0});
      r.irq_rearm = h.reset_drv || (r.pre_select && a[4] && (a[11:10] == 2'h0) &&
                    (a[2:0] == h.irq_level) && (h.irq_level >= 3'h3) && !(h.ior_n && h.iow_n));
      r.buffered_reset_n = !h.reset_drv;
      {r.word_bank, r.word_select, r.byte_select} = {a[15:12], a[0]};
      r.buffered_io_read_n = h.ior_n;
      r.buffered_io_write_n = h.iow_n;
      r.transfer_is_read = !h.ior_n;
      r.transfer_is_write = h.ior_n;
      r.strobe_read_en = r.card_select && !h.ior_n;
      r.strobe_write_en = r.card_select && !h.iow_n;
      return r;
   endfunction

   // pipe is five clocks deep; judge seven clocks later, at a falling edge
   task automatic settle();
      repeat (7) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   task automatic cyc(input logic [15:0] addr, input logic aen, input logic rd, input logic wr);
      aad_host_model_i.drive(addr, aen, !rd, !wr);
      settle();
      check(32'(ctrl_w), 32'(ref_ctrl(host_w)));
   endtask

   task automatic t_host_reset();
      settle();
      check(ctrl_w.irq_rearm, 1'h1);
      check(ctrl_w.buffered_reset_n, 1'h0);
      aad_host_model_i.set_cfg(1'h0, 2'h0, 3'h5);
      settle();
      check({ctrl_w.irq_rearm, ctrl_w.buffered_reset_n}, 2'h1);
      $display("TB: host reset test done");
   endtask

   // every adapter number against every address copy
   task automatic t_window();
      for (int n = 0; n < 4; n++)
      begin
         aad_host_model_i.set_cfg(1'h0, n[1:0], 3'h5);
         for (int k = 0; k < 4; k++)
         begin
            cyc(16'h02E2 | 16'(k << 10), 1'h0, 1'h0, 1'h1);
            check(ctrl_w.card_select, k == n);
            check(ctrl_w.strobe_write_en, k == n);
            cyc(16'h02E3 | 16'(k << 10), 1'h0, 1'h1, 1'h0);
            check({ctrl_w.byte_select, ctrl_w.transfer_is_read, ctrl_w.strobe_read_en},
                  {2'h3, k == n});
         end
      end
      aad_host_model_i.set_cfg(1'h0, 2'h0, 3'h5);
      cyc(16'h02E2, 1'h1, 1'h0, 1'h1);
      check({ctrl_w.pre_select, ctrl_w.card_select, ctrl_w.strobe_write_en}, 3'h0);
      cyc(16'h02F5, 1'h1, 1'h1, 1'h0);
      check(ctrl_w.irq_rearm, 1'h0);
      $display("TB: window and dma test done");
   endtask

   // each level, its neighbour, a foreign adapter number and a near miss
   task automatic t_shared();
      for (int l = 0; l < 8; l++)
      begin
         aad_host_model_i.set_cfg(1'h0, 2'h0, l[2:0]);
         cyc(16'h02F0 | 16'(l), 1'h0, 1'h1, 1'h0);
         check({ctrl_w.irq_rearm, ctrl_w.card_select}, {l >= 3, 1'h0});
         cyc(16'h02F0 | 16'((l + 1) % 8), 1'h0, 1'h0, 1'h1);
         check(ctrl_w.irq_rearm, 1'h0);
         cyc(16'h06F0 | 16'(l), 1'h0, 1'h1, 1'h0);
         check(ctrl_w.irq_rearm, 1'h0);
         cyc(16'h02F8 | 16'(l), 1'h0, 1'h1, 1'h0);
         check(ctrl_w.irq_rearm, 1'h0);
      end
      $display("TB: shared interrupt test done");
   endtask

   task automatic t_near_word();
      int bits[6] = '{9, 8, 7, 6, 5, 3};
      foreach (bits[i])
      begin
         cyc(16'h02E2 ^ 16'(1 << bits[i]), 1'h0, 1'h1, 1'h0);
         check(ctrl_w.pre_select, 1'h0);
      end
      for (int w = 0; w < 16; w++)
      begin
         cyc({w[3:0], 12'h2E2}, 1'h0, 1'h0, 1'h1);
         check({ctrl_w.word_bank, ctrl_w.word_select}, w[3:0]);
      end
      $display("TB: preselect and word select test done");
   endtask

   task test_done();
      $display("TB: checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard, well above the roughly 830 clocks the tests need
   always @(posedge sys_clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT)
      begin
         miscompares++;
         test_done();
      end
   end

   initial
   begin
      sys_clk_i = 1'h0;
      resetn_i = 1'h0;
      repeat (8) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      resetn_i = 1'h1;
      t_host_reset();
      t_window();
      t_shared();
      t_near_word();
      test_done();
   end
endmodule // aad_decode_bench

bind aad_decode aad_decode_chk aad_decode_chk_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
                                                 .host_i(host_i), .ctrl_o(ctrl_o));
